// File: verilog/nip_nested_irq_controller.v
`timescale 1ns/1ps
`include "nip_consts.vh"
module nip_nested_irq_controller (
  input wire clk,
  input wire nrst,
  input wire ce,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [31:0] irq_src,
  input wire low_power_timer_irq,
  output reg core_irq_req,
  output reg [5:0] core_vec_num,
  output reg [31:0] core_vec_addr,
  input wire core_irq_ack,
  input wire core_irq_exit,
  output reg core_exit_busy,
  output reg core_exit_done,
  output reg core_tail_chain
);

// ==========================================
// functions
  function [31:0] merge_bytes;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    integer k;
    begin
      merge_bytes = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k])
          merge_bytes[k*8 +: 8] = new_v[k*8 +: 8];
      end
    end
  endfunction

  // value stored in a priority byte: low bits forced to zero
  function [7:0] prio_byte;
    input [1:0] p;
    begin
      prio_byte = {p, 6'h00};
    end
  endfunction

  // address falls inside the priority words
  function prio_hit;
    input [7:0] a;
    begin
      prio_hit = (a >= `NIP_OFF_PRIO_BASE) && (a <= `NIP_OFF_PRIO_LAST) && (a[1:0] == 2'b00);
    end
  endfunction

  // line number held in one byte lane of a priority word
  function [4:0] prio_line;
    input [7:0] a;
    input [1:0] lane;
    begin
      prio_line = {a[4:2] - 3'd4, lane};
    end
  endfunction

  // exit length in cycles, shorter when chained
  function [3:0] exit_len;
    input chained;
    begin
      exit_len = chained ? 4'd`NIP_CHAIN_CYC : 4'd`NIP_EXIT_CYC;
    end
  endfunction

  localparam ST_IDLE = 3'b001;
  localparam ST_ACTIVE = 3'b010;
  localparam ST_EXIT = 3'b100;

// ==========================================
// input synchronisers, three stages
  reg [31:0] src_s1_r;
  reg [31:0] src_s2_r;
  reg [31:0] src_s3_r;
  wire [31:0] src_raw;
  wire [31:0] src_lvl;
  reg [31:0] src_lvl_r;

  // low-power timer on line 28
  // timer wired in
  assign src_raw = irq_src | ({{31{1'b0}}, low_power_timer_irq} << `NIP_TIMER_LINE);
  assign src_lvl = src_lvl_r;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      src_s1_r <= 32'h0000_0000;
      src_s2_r <= 32'h0000_0000;
      src_s3_r <= 32'h0000_0000;
      src_lvl_r <= 32'h0000_0000;
    end else if (ce) begin
      src_s1_r <= src_raw;
      src_s2_r <= src_s1_r;
      src_s3_r <= src_s2_r;
      // level moves only once stages two and three agree
      src_lvl_r <= (src_s2_r & src_s3_r) | (src_lvl_r & (src_s2_r | src_s3_r));
    end
  end

// ==========================================
// registers
  reg [31:0] enable_r;
  reg [31:0] pend_r;
  reg [31:0] active_r;
  reg [1:0] prio_r [0:31];
  reg [31:0] vtab_r;
  reg [2:0] state_r;
  reg [3:0] cnt_r;
  reg [4:0] cur_line_r;
  reg chain_r;

  wire wr_acc;
  wire rd_acc;
  assign wr_acc = avs_write && avs_waitrequest && ce;
  assign rd_acc = avs_read && avs_waitrequest && ce;

// ==========================================
// write strobes per register
  wire wr_set_en;
  wire wr_clr_en;
  wire wr_set_pd;
  wire wr_clr_pd;
  wire wr_vtab;
  wire wr_prio;
  wire ack_take;
  assign wr_set_en = wr_acc && (avs_address == `NIP_OFF_SET_ENABLE0);
  assign wr_clr_en = wr_acc && (avs_address == `NIP_OFF_CLR_ENABLE0);
  assign wr_set_pd = wr_acc && (avs_address == `NIP_OFF_SET_PEND0);
  assign wr_clr_pd = wr_acc && (avs_address == `NIP_OFF_CLR_PEND0);
  assign wr_vtab = wr_acc && (avs_address == `NIP_OFF_VTAB_BASE);
  assign wr_prio = wr_acc && prio_hit(avs_address);
  // core accepts the dispatched line
  assign ack_take = (state_r == ST_ACTIVE) && core_irq_req && core_irq_ack;

// ==========================================
// arbitration
  reg found;
  reg [4:0] win_line;
  reg [1:0] win_prio;
  reg [31:0] cand;
  integer i;

  always @* begin
    found = 1'b0;
    win_line = 5'h00;
    win_prio = 2'h3;
    cand = pend_r & enable_r & ~active_r;
    for (i = `NIP_NUM_IRQ - 1; i >= 0; i = i - 1) begin
      if (cand[i] && (!found || prio_r[i] <= win_prio)) begin
        found = 1'b1;
        win_line = i[4:0];
        win_prio = prio_r[i];
      end
    end
  end

  // vector number and fetch address
  wire [5:0] win_vec;
  wire [31:0] win_addr;
  assign win_vec = {1'b0, win_line} + 6'd`NIP_EXT_VEC_BASE;
  assign win_addr = vtab_r + {24'h000000, win_vec, 2'b00};

// ==========================================
// register file and pending state
  reg [31:0] wmerged;
  reg [31:0] rdata_nxt;
  integer j;

  always @* begin
    wmerged = merge_bytes(32'h0000_0000, avs_writedata, avs_byteenable);
    rdata_nxt = 32'h0000_0000;
    case (avs_address)
      `NIP_OFF_SET_ENABLE0: rdata_nxt = enable_r;
      `NIP_OFF_CLR_ENABLE0: rdata_nxt = enable_r;
      `NIP_OFF_SET_PEND0: rdata_nxt = pend_r;
      `NIP_OFF_CLR_PEND0: rdata_nxt = pend_r;
      `NIP_OFF_VTAB_BASE: rdata_nxt = vtab_r;
      `NIP_OFF_ACTIVE: rdata_nxt = active_r;
      `NIP_OFF_PEND_RD: rdata_nxt = pend_r & enable_r;
      default: begin
        if (prio_hit(avs_address)) begin
          rdata_nxt = {prio_byte(prio_r[prio_line(avs_address, 2'd3)]),
                       prio_byte(prio_r[prio_line(avs_address, 2'd2)]),
                       prio_byte(prio_r[prio_line(avs_address, 2'd1)]),
                       prio_byte(prio_r[prio_line(avs_address, 2'd0)])};
        end
      end
    endcase
  end

// ==========================================
// next enable and pending state
  reg [31:0] enable_nxt;
  reg [31:0] pend_nxt;

  always @* begin
    enable_nxt = enable_r;
    if (wr_set_en)
      enable_nxt = enable_r | wmerged;
    else if (wr_clr_en)
      enable_nxt = enable_r & ~wmerged;
  end

  always @* begin
    pend_nxt = pend_r;
    if (wr_clr_pd)
      pend_nxt = pend_nxt & ~wmerged;
    if (wr_set_pd)
      pend_nxt = pend_nxt | wmerged;
    if (ack_take)
      pend_nxt[cur_line_r] = 1'b0;
    // sources latch pending; set wins over clear
    pend_nxt = pend_nxt | src_lvl;
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enable_r <= 32'h0000_0000;
      pend_r <= 32'h0000_0000;
      vtab_r <= `NIP_VTAB_RST;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      for (j = 0; j < `NIP_NUM_IRQ; j = j + 1)
        prio_r[j] <= 2'h0;
    end else if (ce) begin
      // one wait cycle, then answer
      avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
      if (rd_acc)
        avs_readdata <= rdata_nxt;
      enable_r <= enable_nxt;
      pend_r <= pend_nxt;
      if (wr_vtab)
        vtab_r <= merge_bytes(vtab_r, avs_writedata, avs_byteenable) & `NIP_VTAB_MASK;
      if (wr_prio) begin
        for (j = 0; j < 4; j = j + 1) begin
          if (avs_byteenable[j])
            prio_r[prio_line(avs_address, j[1:0])] <= avs_writedata[j*8 + `NIP_PRIO_LSB +: 2];
        end
      end
    end
  end

// ==========================================
// dispatch and exit timing
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      cur_line_r <= 5'h00;
      chain_r <= 1'b0;
      active_r <= 32'h0000_0000;
      core_irq_req <= 1'b0;
      core_vec_num <= 6'h00;
      core_vec_addr <= 32'h0000_0000;
      core_exit_busy <= 1'b0;
      core_exit_done <= 1'b0;
      core_tail_chain <= 1'b0;
    end else if (ce) begin
      core_exit_done <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          core_tail_chain <= 1'b0;
          if (found) begin
            core_irq_req <= 1'b1;
            core_vec_num <= win_vec;
            core_vec_addr <= win_addr;
            cur_line_r <= win_line;
            state_r <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (core_irq_req && core_irq_ack) begin
            core_irq_req <= 1'b0;
            active_r[cur_line_r] <= 1'b1;
          end else if (!core_irq_req && core_irq_exit) begin
            active_r[cur_line_r] <= 1'b0;
            chain_r <= found;
            core_tail_chain <= found;
            core_exit_busy <= 1'b1;
            cnt_r <= exit_len(found);
            state_r <= ST_EXIT;
          end
        end
        ST_EXIT: begin
          if (cnt_r == 4'd1) begin
            core_exit_busy <= 1'b0;
            core_exit_done <= 1'b1;
            core_tail_chain <= 1'b0;
            state_r <= ST_IDLE;
            if (chain_r && found) begin
              core_irq_req <= 1'b1;
              core_vec_num <= win_vec;
              core_vec_addr <= win_addr;
              cur_line_r <= win_line;
              state_r <= ST_ACTIVE;
            end
          end
          cnt_r <= cnt_r - 4'd1;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // nip_nested_irq_controller

// File: verilog/nip_consts.vh
`ifndef NIP_CONSTS_VH
`define NIP_CONSTS_VH
// ==========================================
// register byte offsets
`define NIP_OFF_SET_ENABLE0 8'h00
`define NIP_OFF_CLR_ENABLE0 8'h04
`define NIP_OFF_SET_PEND0 8'h08
`define NIP_OFF_CLR_PEND0 8'h0c
`define NIP_OFF_PRIO_BASE 8'h10
`define NIP_OFF_PRIO_LAST 8'h2c
`define NIP_OFF_VTAB_BASE 8'h30
`define NIP_OFF_ACTIVE 8'h34
`define NIP_OFF_PEND_RD 8'h38
// ==========================================
// sizes and fields
`define NIP_NUM_IRQ 32
`define NIP_WORD_BITS 32
`define NIP_PRIO_MSB 7
`define NIP_PRIO_LSB 6
`define NIP_TIMER_LINE 28
`define NIP_EXT_VEC_BASE 16
`define NIP_VEC_BYTES 4
// ==========================================
// reset value and write mask of the table base
`define NIP_VTAB_RST 32'h0000_0000
`define NIP_VTAB_MASK 32'hffff_ff80
// ==========================================
// timing
`define NIP_EXIT_CYC 15
`define NIP_CHAIN_CYC 11
`endif

// File: test/nip_irq_properties.sv
`timescale 1ns/1ps
// ====
// port checks
module nip_irq_properties (
  input wire clk,
  input wire nrst,
  input wire ce,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire core_irq_req,
  input wire [5:0] core_vec_num,
  input wire [31:0] core_vec_addr,
  input wire core_irq_ack,
  input wire core_exit_busy,
  input wire core_exit_done,
  input wire core_tail_chain
);
  logic [7:0] ex_cnt;
  logic chain_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // length of the last exit
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ex_cnt <= 8'h00;
      chain_r <= 1'b0;
    end else begin
      ex_cnt <= core_exit_busy ? ex_cnt + {7'h00, ce} : 8'h00;
      if (core_exit_busy) chain_r <= core_tail_chain;
    end
  end
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
    else $error("access not answered after one wait");
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
  AST_PRIO_LOW: assert property (avs_read && !avs_waitrequest && avs_address >= 8'h10 && avs_address <= 8'h2c
    |-> (avs_readdata & 32'h3f3f3f3f) == 32'h0) else $error("priority low bits not zero");
  AST_BASE_LOW: assert property (avs_read && !avs_waitrequest && avs_address == 8'h30 |-> avs_readdata[6:0] == 7'h00)
    else $error("table base low bits not zero");
  AST_VEC_RANGE: assert property (core_irq_req |-> core_vec_num >= 6'd16 && core_vec_num <= 6'd47)
    else $error("vector number out of range");
  AST_VEC_ADDR: assert property (core_irq_req |-> core_vec_addr[6:0] == {core_vec_num[4:0], 2'b00})
    else $error("vector address not four times vector");
  AST_REQ_HOLD: assert property (core_irq_req && !core_irq_ack && ce |=> core_irq_req) else $error("request dropped");
  AST_ACK_DROP: assert property (core_irq_req && core_irq_ack && ce |=> !core_irq_req) else $error("request kept");
  AST_EXIT_LEN: assert property ($fell(core_exit_busy) |-> ex_cnt == (chain_r ? 8'd11 : 8'd15))
    else $error("exit length wrong");
  AST_DONE_PULSE: assert property (core_exit_done |=> !core_exit_done) else $error("exit done too long");
  AST_CHAIN_IN_EXIT: assert property (core_tail_chain |-> core_exit_busy) else $error("chain flag outside exit");
  cover property (core_irq_req && core_irq_ack);
  cover property ($fell(core_exit_busy) && chain_r);
  cover property ($fell(core_exit_busy) && !chain_r);
endmodule // nip_irq_properties

// File: test/nip_core_model.sv
`timescale 1ns/1ps
// ====
// core side: accepts, runs handler, returns
module nip_core_model (
  input wire clk,
  input wire nrst,
  input wire core_irq_req,
  input wire [5:0] core_vec_num,
  input wire [31:0] core_vec_addr,
  input wire core_exit_done,
  input wire [3:0] dly,
  output reg core_irq_ack,
  output reg core_irq_exit,
  output reg taken,
  output reg [5:0] t_vec,
  output reg [31:0] t_addr
);
  reg [2:0] ph;
  reg [3:0] n;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph <= 3'd0; n <= 4'h0; core_irq_ack <= 1'b0; core_irq_exit <= 1'b0;
      taken <= 1'b0; t_vec <= 6'h00; t_addr <= 32'h0;
    end else begin
      taken <= 1'b0;
      core_irq_exit <= 1'b0;
      case (ph)
        3'd0: if (core_irq_req) begin n <= dly; ph <= 3'd1; end
        3'd1: if (n != 4'h0) n <= n - 4'h1; else begin core_irq_ack <= 1'b1; ph <= 3'd2; end
        3'd2: begin
          core_irq_ack <= 1'b0; taken <= 1'b1; t_vec <= core_vec_num; t_addr <= core_vec_addr;
          n <= dly; ph <= 3'd3;
        end
        3'd3: if (n != 4'h0) n <= n - 4'h1; else begin core_irq_exit <= 1'b1; ph <= 3'd4; end
        default: if (core_exit_done) ph <= 3'd0;
      endcase
    end
  end
endmodule // nip_core_model

// File: test/test_nested_irq_enable_priority.sv
`timescale 1ns/1ps
// ====
// bench
module test_nested_irq_enable_priority;
  logic clk, nrst, ce, rd, wr, lpt, ack, ex, taken;
  logic [7:0] adr;
  logic [31:0] wd, rdata, src, q, r, r2, base, t_addr, vaddr_w;
  logic [3:0] dly;
  logic [5:0] vnum, t_vec;
  wire wreq, req, busy, done, chain;
  integer miscompares, n_compared, k;
  nip_nested_irq_controller dut (.clk(clk), .nrst(nrst), .ce(ce), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wreq), .irq_src(src),
    .low_power_timer_irq(lpt), .core_irq_req(req), .core_vec_num(vnum), .core_vec_addr(vaddr_w),
    .core_irq_ack(ack), .core_irq_exit(ex), .core_exit_busy(busy), .core_exit_done(done), .core_tail_chain(chain));
  nip_core_model core (.clk(clk), .nrst(nrst), .core_irq_req(req), .core_vec_num(vnum), .core_vec_addr(vaddr_w),
    .core_exit_done(done), .dly(dly), .core_irq_ack(ack), .core_irq_exit(ex), .taken(taken), .t_vec(t_vec),
    .t_addr(t_addr));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic [31:0] vaddr(input [31:0] b, input integer line);
    vaddr = (b & 32'hffffff80) + (line + 16) * 4;
  endfunction
  task conclude;
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer i;
    @(posedge clk);
    adr <= a; wd <= d; rd <= !w; wr <= w;
    i = 0;
    @(posedge clk);
    while (wreq !== 1'b0 && i < 50) begin @(posedge clk); i++; end
    q = rdata;
    rd <= 1'b0; wr <= 1'b0;
    if (i == 50) begin miscompares++; conclude; end
  endtask
  task take(input logic [5:0] v, input logic [31:0] a);
    integer i;
    i = 0;
    @(posedge clk);
    while (taken !== 1'b1 && i < 400) begin @(posedge clk); i++; end
    if (i == 400) begin miscompares++; conclude; end
    chk({26'h0, t_vec}, {26'h0, v});
    chk(t_addr, a);
  endtask
  initial begin
    nrst = 1'b0; ce = 1'b1; rd = 1'b0; wr = 1'b0; adr = 8'h00; wd = 32'h0; src = 32'h0; lpt = 1'b0; dly = 4'h0;
    miscompares = 0; n_compared = 0;
    void'($urandom(50945));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    bus(0, 8'h30, 0); chk(q, 32'h0);
    bus(0, 8'h3c, 0); chk(q, 32'h0);
    $display("reset test done");
    for (k = 0; k < 8; k++) begin
      r = $urandom; bus(1, 8'h10 + 4 * k, r); bus(0, 8'h10 + 4 * k, 0); chk(q, r & 32'hc0c0c0c0);
    end
    $display("priority test done");
    r = $urandom; r2 = $urandom; bus(1, 8'h00, r); bus(1, 8'h00, r2);
    bus(0, 8'h00, 0); chk(q, r | r2);
    bus(1, 8'h04, 32'hffffffff); bus(0, 8'h00, 0); chk(q, 32'h0);
    src <= 32'h180; repeat (6) @(posedge clk); src <= 32'h0; repeat (4) @(posedge clk);
    bus(0, 8'h0c, 0); chk(q, 32'h180);
    bus(1, 8'h0c, 32'h80); bus(0, 8'h0c, 0); chk(q, 32'h100);
    bus(1, 8'h0c, 32'h100);
    $display("enable and pending test done");
    base = $urandom & 32'hffffff80; bus(1, 8'h30, base); bus(0, 8'h30, 0); chk(q, base);
    bus(1, 8'h2c, 32'hc0000000); bus(1, 8'h0c, 32'h10000000); bus(1, 8'h00, 32'h10000000);
    dly <= $urandom; lpt <= 1'b1; repeat (3) @(posedge clk); lpt <= 1'b0;
    take(6'd44, base + 32'hb0);
    $display("timer test done");
    bus(1, 8'h10, 32'h80000000); bus(1, 8'h14, 32'h4000); bus(1, 8'h18, 32'h4000); bus(1, 8'h00, 32'h228);
    dly <= $urandom; src <= 32'h228; repeat (3) @(posedge clk); src <= 32'h0;
    take(6'd21, vaddr(base, 5));
    take(6'd25, vaddr(base, 9));
    take(6'd19, vaddr(base, 3));
    $display("order test done");
    conclude;
  end
endmodule // test_nested_irq_enable_priority
bind nip_nested_irq_controller nip_irq_properties chk_i (.*);
